// >>> design/impedance_channel_config_regs.vh
// Purpose: constants for the impedance channel configuration block
// Assumes: APB byte address is four times the register index
// Notes:   definitions only
// What this block does
// - osr codes 6,7 give 512 and 1024
// - bias enable powers bandgap, about 200ms startup
// - q enable turns drive, q rx, pll, bandgap
// - i enable turns drive, i rx, pll, bandgap
// - highpass: 0 bypass, 1 low, 2-3 high cutoff
// - lowpass: 0 bypass, 1-3 stepped, 4-7 widest
// - compare source i, q or magnitude; 3 reserved
// - disabled channel reads as zero in magnitude
// - compare selected value against upper, lower thresholds
// - compare disabled leaves outcome untouched
// - internal resistors: voltage and range set current
// - internal mode lets safety logic overwrite drive fields
// - external resistor mode never overwrites voltage magnitude
// - lead-off status needs condition held about 128ms
// - immediate lead-off bypasses the debounce window
`ifndef IMPEDANCE_CHANNEL_CONFIG_REGS_VH
`define IMPEDANCE_CHANNEL_CONFIG_REGS_VH

// ***********************************************
// register indices (byte address = index * 4)
// ***********************************************
`define IDX_CHAN_ENABLE_CONFIG 8'h20
`define IDX_CHANNEL_FILTER_THRESHOLD_CONFIG 8'h21
`define IDX_STIMULUS_LEADOFF_CONFIG 8'h22
`define IDX_LOWER_THRESHOLD 8'h26
`define IDX_UPPER_THRESHOLD 8'h27
`define IDX_EVENT_STATUS 8'h30
`define IDX_EVENT_MASK 8'h31
`define IDX_LIVE_STATE 8'h32

// ***********************************************
// field positions
// ***********************************************
`define F_I_EN 0
`define F_Q_EN 1
`define F_BG_EN 2
`define F_OSR_LSB 3
`define F_THR_EN 0
`define F_CMP_LSB 1
`define F_LPF_LSB 3
`define F_HPF_LSB 6
`define F_STIM_LSB 0
`define F_IRGE_LSB 2
`define F_VDRV_LSB 4
`define F_RAPID 6
`define F_EXT_RES 7
`define EV_ABOVE 0
`define EV_BELOW 1
`define EV_LEADOFF 2

// ***********************************************
// reset values and codes
// ***********************************************
`define RST_REG8 8'h00
`define RST_EV 3'h0
`define CMP_I 2'h0
`define CMP_Q 2'h1
`define CMP_MAG 2'h2

// ***********************************************
// timing
// ***********************************************
`define CLK_HZ 25000000
`define BIAS_STARTUP_MS 200
`define LEADOFF_WINDOW_MS 128
`define BIAS_STARTUP_CYC ((`CLK_HZ / 1000) * `BIAS_STARTUP_MS)
`define LEADOFF_WINDOW_CYC ((`CLK_HZ / 1000) * `LEADOFF_WINDOW_MS)

`endif

// >>> design/impedance_channel_config.v
// Purpose: configuration registers and threshold / lead-off logic of an impedance channel
// Assumes: APB slave, zero wait states, single clock REF_CLK, sync reset SYS_RST
// Notes:   threshold compare uses bits [19:12] of the selected 20-bit magnitude
`timescale 1ns/1ps
`include "impedance_channel_config_regs.vh"
`default_nettype none

module impedance_channel_config #(
   parameter integer BIAS_CYC = `BIAS_STARTUP_CYC,
   parameter integer LEADOFF_CYC = `LEADOFF_WINDOW_CYC
) (
   input wire REF_CLK,
   input wire SYS_RST,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PWDATA,
   output wire [31:0] PRDATA,
   output wire PREADY,
   output wire PSLVERR,
   input wire SAMPLE_VALID,
   input wire [19:0] INPHASE_DATA,
   input wire [19:0] QUADRATURE_DATA,
   input wire LEADOFF_RAW,
   input wire SAFETY_OVERRIDE,
   input wire [1:0] SAFETY_VDRV,
   input wire [1:0] SAFETY_IRGE,
   output reg [10:0] CONVERTER_OVERSAMPLING,
   output wire BANDGAP_ON,
   output wire BIAS_READY,
   output wire PLL_ON,
   output wire DRIVE_ON,
   output wire INPHASE_RX_ON,
   output wire QUADRATURE_RX_ON,
   output wire HIGHPASS_BYPASS,
   output wire HIGHPASS_WIDE,
   output wire LOWPASS_BYPASS,
   output reg [1:0] LOWPASS_STEP,
   output wire EXTERNAL_RESISTOR,
   output wire [1:0] DRIVE_VOLTAGE_MAGNITUDE,
   output wire [1:0] DRIVE_CURRENT_RANGE,
   output wire [1:0] STIMULUS_TYPE,
   output wire ABOVE_THRESHOLD,
   output wire BELOW_THRESHOLD,
   output wire LEADOFF_STATUS,
   output wire IRQ
);

   // ***********************************************
   // registers and bus decode
   // ***********************************************
   reg [7:0] enable_cfg_q;
   reg [7:0] filter_cfg_q;
   reg [7:0] stim_cfg_q;
   reg [7:0] lower_thr_q;
   reg [7:0] upper_thr_q;
   reg [2:0] ev_status_q;
   reg [2:0] ev_mask_q;
   reg above_q;
   reg below_q;
   reg leadoff_q;
   reg [22:0] bias_cnt_q;
   reg [22:0] loff_cnt_q;
   reg [31:0] rdata;
   reg hit;

   wire [9:0] word_idx = PADDR[11:2];
   wire bus_wr = PSEL & PENABLE & PWRITE;
   wire sel_en = (word_idx == {2'b00, `IDX_CHAN_ENABLE_CONFIG});
   wire sel_flt = (word_idx == {2'b00, `IDX_CHANNEL_FILTER_THRESHOLD_CONFIG});
   wire sel_stim = (word_idx == {2'b00, `IDX_STIMULUS_LEADOFF_CONFIG});
   wire sel_lo = (word_idx == {2'b00, `IDX_LOWER_THRESHOLD});
   wire sel_hi = (word_idx == {2'b00, `IDX_UPPER_THRESHOLD});
   wire sel_st = (word_idx == {2'b00, `IDX_EVENT_STATUS});
   wire sel_mk = (word_idx == {2'b00, `IDX_EVENT_MASK});
   wire sel_live = (word_idx == {2'b00, `IDX_LIVE_STATE});

   always @* begin
      rdata = 32'h0000_0000;
      hit = 1'b1;
      if (sel_en) begin
         rdata[7:0] = enable_cfg_q;
      end else if (sel_flt) begin
         rdata[7:0] = filter_cfg_q;
      end else if (sel_stim) begin
         rdata[7:0] = stim_cfg_q;
      end else if (sel_lo) begin
         rdata[7:0] = lower_thr_q;
      end else if (sel_hi) begin
         rdata[7:0] = upper_thr_q;
      end else if (sel_st) begin
         rdata[2:0] = ev_status_q;
      end else if (sel_mk) begin
         rdata[2:0] = ev_mask_q;
      end else if (sel_live) begin
         rdata[3:0] = {BIAS_READY, leadoff_q, below_q, above_q};
      end else begin
         hit = 1'b0;
      end
   end

   assign PRDATA = (PSEL & ~PWRITE) ? rdata : 32'h0000_0000;
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~hit;

   // ***********************************************
   // enable and converter configuration
   // ***********************************************
   wire i_en = enable_cfg_q[`F_I_EN];
   wire q_en = enable_cfg_q[`F_Q_EN];
   wire bg_en = enable_cfg_q[`F_BG_EN];
   wire [2:0] osr_code = enable_cfg_q[`F_OSR_LSB +: 3];

   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         enable_cfg_q <= `RST_REG8;
         filter_cfg_q <= `RST_REG8;
         lower_thr_q <= `RST_REG8;
         upper_thr_q <= `RST_REG8;
         ev_mask_q <= `RST_EV;
      end else if (bus_wr) begin
         if (sel_en) begin
            enable_cfg_q <= {2'b00, PWDATA[5:0]};
         end
         if (sel_flt) begin
            filter_cfg_q <= PWDATA[7:0];
         end
         if (sel_lo) begin
            lower_thr_q <= PWDATA[7:0];
         end
         if (sel_hi) begin
            upper_thr_q <= PWDATA[7:0];
         end
         if (sel_mk) begin
            ev_mask_q <= PWDATA[2:0];
         end
      end
   end

   always @* begin
      case (osr_code)
         3'h0: CONVERTER_OVERSAMPLING = 11'h008;
         3'h1: CONVERTER_OVERSAMPLING = 11'h010;
         3'h2: CONVERTER_OVERSAMPLING = 11'h020;
         3'h3: CONVERTER_OVERSAMPLING = 11'h040;
         3'h4: CONVERTER_OVERSAMPLING = 11'h080;
         3'h5: CONVERTER_OVERSAMPLING = 11'h100;
         3'h6: CONVERTER_OVERSAMPLING = 11'h200;
         3'h7: CONVERTER_OVERSAMPLING = 11'h400;
         default: CONVERTER_OVERSAMPLING = 11'h008;
      endcase
   end

   // either receive channel pulls in drive, pll and bandgap even if software forgot
   assign INPHASE_RX_ON = i_en;
   assign QUADRATURE_RX_ON = q_en;
   assign DRIVE_ON = i_en | q_en;
   assign PLL_ON = i_en | q_en;
   assign BANDGAP_ON = bg_en | i_en | q_en;

   // bias settle timer restarts whenever the bandgap drops
   always @(posedge REF_CLK) begin
      if (SYS_RST | ~BANDGAP_ON) begin
         bias_cnt_q <= 23'h00_0000;
      end else if (bias_cnt_q < BIAS_CYC[22:0]) begin
         bias_cnt_q <= bias_cnt_q + 23'h00_0001;
      end
   end
   assign BIAS_READY = BANDGAP_ON & (bias_cnt_q >= BIAS_CYC[22:0]);

   // ***********************************************
   // filter selects
   // ***********************************************
   wire [1:0] hpf_code = filter_cfg_q[`F_HPF_LSB +: 2];
   wire [2:0] lpf_code = filter_cfg_q[`F_LPF_LSB +: 3];
   assign HIGHPASS_BYPASS = (hpf_code == 2'h0);
   assign HIGHPASS_WIDE = hpf_code[1];
   assign LOWPASS_BYPASS = (lpf_code == 3'h0);

   always @* begin
      if (lpf_code[2]) begin
         LOWPASS_STEP = 2'h3;
      end else if (lpf_code == 3'h0) begin
         LOWPASS_STEP = 2'h0;
      end else begin
         LOWPASS_STEP = lpf_code[1:0] - 2'h1;
      end
   end

   // ***********************************************
   // threshold compare
   // ***********************************************
   wire thr_en = filter_cfg_q[`F_THR_EN];
   wire [1:0] cmp_sel = filter_cfg_q[`F_CMP_LSB +: 2];
   wire [19:0] i_eff = i_en ? INPHASE_DATA : 20'h0_0000;
   wire [19:0] q_eff = q_en ? QUADRATURE_DATA : 20'h0_0000;
   wire [19:0] i_abs = i_eff[19] ? (20'h0_0000 - i_eff) : i_eff;
   wire [19:0] q_abs = q_eff[19] ? (20'h0_0000 - q_eff) : q_eff;

   // bit-serial square root: one result bit per clock, 20 clocks per sample
   reg sq_busy_q;
   reg [4:0] sq_bit_q;
   reg [19:0] sq_root_q;
   reg [39:0] sq_sum_q;
   reg cmp_go;
   reg [19:0] cmp_val;
   wire [19:0] sq_trial = sq_root_q | (20'h0_0001 << sq_bit_q);
   wire [39:0] sq_trial_sq = sq_trial * sq_trial;
   wire sq_start = SAMPLE_VALID & thr_en & (cmp_sel == `CMP_MAG) & ~sq_busy_q;

   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         sq_busy_q <= 1'b0;
         sq_bit_q <= 5'h00;
         sq_root_q <= 20'h0_0000;
         sq_sum_q <= 40'h00_0000_0000;
      end else if (sq_start) begin
         sq_busy_q <= 1'b1;
         sq_bit_q <= 5'h13;
         sq_root_q <= 20'h0_0000;
         sq_sum_q <= i_abs * i_abs + q_abs * q_abs;
      end else if (sq_busy_q) begin
         if (sq_trial_sq <= sq_sum_q) begin
            sq_root_q <= sq_trial;
         end
         if (sq_bit_q == 5'h00) begin
            sq_busy_q <= 1'b0;
         end else begin
            sq_bit_q <= sq_bit_q - 5'h01;
         end
      end
   end

   // result of the last square-root step, taken the same cycle it completes
   wire [19:0] sq_final = (sq_trial_sq <= sq_sum_q) ? sq_trial : sq_root_q;

   always @* begin
      cmp_go = 1'b0;
      cmp_val = 20'h0_0000;
      case (cmp_sel)
         `CMP_I: begin
            cmp_go = SAMPLE_VALID;
            cmp_val = i_abs;
         end
         `CMP_Q: begin
            cmp_go = SAMPLE_VALID;
            cmp_val = q_abs;
         end
         `CMP_MAG: begin
            cmp_go = sq_busy_q & (sq_bit_q == 5'h00);
            cmp_val = sq_final;
         end
         default: begin
            // reserved source: nothing is compared
            cmp_go = 1'b0;
            cmp_val = 20'h0_0000;
         end
      endcase
   end

   wire cmp_fire = cmp_go & thr_en;
   wire over_now = cmp_val[19:12] > upper_thr_q;
   wire under_now = cmp_val[19:12] < lower_thr_q;

   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         above_q <= 1'b0;
         below_q <= 1'b0;
      end else if (cmp_fire) begin
         above_q <= over_now;
         below_q <= under_now;
      end
   end
   assign ABOVE_THRESHOLD = above_q;
   assign BELOW_THRESHOLD = below_q;

   // ***********************************************
   // stimulus configuration with safety override
   // ***********************************************
   wire ext_res = stim_cfg_q[`F_EXT_RES];
   wire rapid = stim_cfg_q[`F_RAPID];

   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         stim_cfg_q <= `RST_REG8;
      end else if (SAFETY_OVERRIDE & ~ext_res) begin
         // safety limits win over a software write in the same cycle
         stim_cfg_q[`F_VDRV_LSB +: 2] <= SAFETY_VDRV;
         stim_cfg_q[`F_IRGE_LSB +: 2] <= SAFETY_IRGE;
         if (bus_wr & sel_stim) begin
            stim_cfg_q[7:6] <= PWDATA[7:6];
            stim_cfg_q[1:0] <= PWDATA[1:0];
         end
      end else if (bus_wr & sel_stim) begin
         stim_cfg_q <= PWDATA[7:0];
      end
   end

   assign EXTERNAL_RESISTOR = ext_res;
   assign DRIVE_VOLTAGE_MAGNITUDE = stim_cfg_q[`F_VDRV_LSB +: 2];
   assign DRIVE_CURRENT_RANGE = stim_cfg_q[`F_IRGE_LSB +: 2];
   assign STIMULUS_TYPE = stim_cfg_q[`F_STIM_LSB +: 2];

   // ***********************************************
   // dc lead-off debounce
   // ***********************************************
   always @(posedge REF_CLK) begin
      if (SYS_RST | ~LEADOFF_RAW) begin
         loff_cnt_q <= 23'h00_0000;
      end else if (loff_cnt_q < LEADOFF_CYC[22:0]) begin
         loff_cnt_q <= loff_cnt_q + 23'h00_0001;
      end
   end

   wire loff_d = LEADOFF_RAW & (rapid | (loff_cnt_q >= LEADOFF_CYC[22:0]));

   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         leadoff_q <= 1'b0;
      end else begin
         leadoff_q <= loff_d;
      end
   end
   assign LEADOFF_STATUS = leadoff_q;

   // ***********************************************
   // interrupts: sticky, write one to clear, set wins
   // ***********************************************
   wire [2:0] ev_set;
   assign ev_set[`EV_ABOVE] = cmp_fire & over_now;
   assign ev_set[`EV_BELOW] = cmp_fire & under_now;
   assign ev_set[`EV_LEADOFF] = loff_d & ~leadoff_q;
   wire [2:0] ev_clr = (bus_wr & sel_st) ? PWDATA[2:0] : 3'h0;

   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         ev_status_q <= `RST_EV;
      end else begin
         ev_status_q <= (ev_status_q & ~ev_clr) | ev_set;
      end
   end
   assign IRQ = |(ev_status_q & ev_mask_q);

endmodule // impedance_channel_config

`default_nettype wire

// >>> tb/impedance_channel_config_props.sv
// Purpose: concurrent checks on the impedance channel configuration ports
// Assumes: zero wait APB, compare enable and lead-off mode mirrored from bus writes
// Notes:   bound to the top module, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module impedance_channel_config_props #(
   parameter integer LEADOFF_CYC = 10
) (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic PREADY,
   input wire logic LEADOFF_RAW,
   input wire logic SAFETY_OVERRIDE,
   input wire logic [1:0] SAFETY_VDRV,
   input wire logic [1:0] SAFETY_IRGE,
   input wire logic [10:0] CONVERTER_OVERSAMPLING,
   input wire logic BANDGAP_ON,
   input wire logic PLL_ON,
   input wire logic DRIVE_ON,
   input wire logic INPHASE_RX_ON,
   input wire logic QUADRATURE_RX_ON,
   input wire logic HIGHPASS_BYPASS,
   input wire logic HIGHPASS_WIDE,
   input wire logic LOWPASS_BYPASS,
   input wire logic [1:0] LOWPASS_STEP,
   input wire logic EXTERNAL_RESISTOR,
   input wire logic [1:0] DRIVE_VOLTAGE_MAGNITUDE,
   input wire logic [1:0] DRIVE_CURRENT_RANGE,
   input wire logic ABOVE_THRESHOLD,
   input wire logic BELOW_THRESHOLD,
   input wire logic LEADOFF_STATUS
);
   logic en_q, imm_q;
   int run_q;
   wire logic wr = PSEL && PENABLE && PWRITE && PREADY;
   // ****************************************
   // mirrors of the bits that gate behaviour
   // ****************************************
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         en_q <= 1'b0;
         imm_q <= 1'b0;
         run_q <= 0;
      end else begin
         if (wr && PADDR == 12'h084) en_q <= PWDATA[0];
         if (wr && PADDR == 12'h088) imm_q <= PWDATA[6];
         run_q <= LEADOFF_RAW ? run_q + 1 : 0;
      end
   end
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);
   a_osr_top: assert property (
      wr && PADDR == 12'h080 && PWDATA[5:3] == 3'h7 |=> CONVERTER_OVERSAMPLING == 11'h400)
      else $error("oversampling code 7 wrong");
   a_osr_mid: assert property (
      wr && PADDR == 12'h080 && PWDATA[5:3] == 3'h6 |=> CONVERTER_OVERSAMPLING == 11'h200)
      else $error("oversampling code 6 wrong");
   a_rx_power: assert property (
      INPHASE_RX_ON || QUADRATURE_RX_ON |-> PLL_ON && DRIVE_ON && BANDGAP_ON)
      else $error("receive on without pll, drive or bandgap");
   a_hpf_off: assert property (
      wr && PADDR == 12'h084 && PWDATA[7:6] == 2'h0 |=> HIGHPASS_BYPASS && !HIGHPASS_WIDE)
      else $error("highpass code 0 not bypass");
   a_lpf_wide: assert property (
      wr && PADDR == 12'h084 && PWDATA[5] |=> LOWPASS_STEP == 2'h3 && !LOWPASS_BYPASS)
      else $error("lowpass codes 4-7 not widest");
   a_safety_take: assert property (
      !EXTERNAL_RESISTOR && SAFETY_OVERRIDE |=> DRIVE_VOLTAGE_MAGNITUDE == $past(SAFETY_VDRV)
      && DRIVE_CURRENT_RANGE == $past(SAFETY_IRGE)) else $error("safety overwrite missed");
   a_ext_hold: assert property (
      EXTERNAL_RESISTOR && SAFETY_OVERRIDE && !(wr && PADDR == 12'h088)
      |=> $stable(DRIVE_VOLTAGE_MAGNITUDE)) else $error("voltage overwritten in ext mode");
   a_thr_frozen: assert property (
      !en_q |=> $stable(ABOVE_THRESHOLD) && $stable(BELOW_THRESHOLD))
      else $error("flags moved with compare off");
   a_lo_window: assert property (
      $rose(LEADOFF_STATUS) && !imm_q |-> run_q >= LEADOFF_CYC)
      else $error("lead-off status before window");
   a_lo_drop: assert property (
      LEADOFF_STATUS && !LEADOFF_RAW |=> !LEADOFF_STATUS) else $error("lead-off status held");
   a_lo_fast: assert property (
      imm_q && LEADOFF_RAW |=> LEADOFF_STATUS) else $error("immediate lead-off late");
endmodule // impedance_channel_config_props
bind impedance_channel_config impedance_channel_config_props #(.LEADOFF_CYC(LEADOFF_CYC)) u_props (
   .REF_CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY, .LEADOFF_RAW,
   .SAFETY_OVERRIDE, .SAFETY_VDRV, .SAFETY_IRGE, .CONVERTER_OVERSAMPLING, .BANDGAP_ON, .PLL_ON,
   .DRIVE_ON, .INPHASE_RX_ON, .QUADRATURE_RX_ON, .HIGHPASS_BYPASS, .HIGHPASS_WIDE, .LOWPASS_BYPASS,
   .LOWPASS_STEP, .EXTERNAL_RESISTOR, .DRIVE_VOLTAGE_MAGNITUDE, .DRIVE_CURRENT_RANGE,
   .ABOVE_THRESHOLD, .BELOW_THRESHOLD, .LEADOFF_STATUS);
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: self-checking bench for the impedance channel configuration block
// Assumes: short bias and lead-off counts through parameters
// Notes:   reads queue their expected {error, data}; a monitor compares on completion
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic REF_CLK = 1'b0, SYS_RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic SAMPLE_VALID = 1'b0, LEADOFF_RAW = 1'b0, SAFETY_OVERRIDE = 1'b0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0000_0000;
   logic [19:0] INPHASE_DATA = 20'h0_0000, QUADRATURE_DATA = 20'h0_0000;
   logic [1:0] SAFETY_VDRV = 2'h0, SAFETY_IRGE = 2'h0, v, r;
   wire [31:0] PRDATA;
   wire PREADY, PSLVERR, BANDGAP_ON, BIAS_READY, PLL_ON, DRIVE_ON, INPHASE_RX_ON, QUADRATURE_RX_ON;
   wire HIGHPASS_BYPASS, HIGHPASS_WIDE, LOWPASS_BYPASS, EXTERNAL_RESISTOR, ABOVE_THRESHOLD;
   wire BELOW_THRESHOLD, LEADOFF_STATUS, IRQ;
   wire [10:0] CONVERTER_OVERSAMPLING;
   wire [1:0] LOWPASS_STEP, DRIVE_VOLTAGE_MAGNITUDE, DRIVE_CURRENT_RANGE, STIMULUS_TYPE;
   int num_errors = 0, compares = 0, k;
   logic [32:0] exq[$];
   logic [32:0] got;
   logic [11:0] ra[9] = '{12'h080, 12'h084, 12'h088, 12'h098, 12'h09C, 12'h0C0, 12'h0C4,
      12'h0C8, 12'h0A0};
   impedance_channel_config #(.BIAS_CYC(20), .LEADOFF_CYC(10)) u_impedance_channel_config (
      .REF_CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
      .SAMPLE_VALID, .INPHASE_DATA, .QUADRATURE_DATA, .LEADOFF_RAW, .SAFETY_OVERRIDE,
      .SAFETY_VDRV, .SAFETY_IRGE, .CONVERTER_OVERSAMPLING, .BANDGAP_ON, .BIAS_READY, .PLL_ON,
      .DRIVE_ON, .INPHASE_RX_ON, .QUADRATURE_RX_ON, .HIGHPASS_BYPASS, .HIGHPASS_WIDE,
      .LOWPASS_BYPASS, .LOWPASS_STEP, .EXTERNAL_RESISTOR, .DRIVE_VOLTAGE_MAGNITUDE,
      .DRIVE_CURRENT_RANGE, .STIMULUS_TYPE, .ABOVE_THRESHOLD, .BELOW_THRESHOLD,
      .LEADOFF_STATUS, .IRQ);
   initial begin
      forever #20 REF_CLK = ~REF_CLK;
   end
   // ****************************************
   // shared tasks
   // ****************************************
   task chk(input logic [32:0] s, input logic [32:0] e);
      compares++;
      if (s !== e) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, s, e);
      end
   endtask
   task nw(input int n);
      repeat (n) @(negedge REF_CLK);
   endtask
   // a read carries its expected {error, data} in e; a write sends e[31:0]
   task apb(input logic w, input logic [11:0] a, input logic [32:0] e);
      @(posedge REF_CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= e[31:0];
      if (!w) exq.push_back(e);
      @(posedge REF_CLK);
      PENABLE <= 1'b1;
      @(posedge REF_CLK);
      while (PREADY !== 1'b1) @(posedge REF_CLK);
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task smp(input logic [19:0] i, input logic [19:0] q);
      @(posedge REF_CLK);
      SAMPLE_VALID <= 1'b1;
      INPHASE_DATA <= i;
      QUADRATURE_DATA <= q;
      @(posedge REF_CLK);
      SAMPLE_VALID <= 1'b0;
      INPHASE_DATA <= 20'($urandom);
      QUADRATURE_DATA <= 20'($urandom);
   endtask
   task ovr;
      @(posedge REF_CLK);
      SAFETY_OVERRIDE <= 1'b1;
      SAFETY_VDRV <= v;
      SAFETY_IRGE <= r;
      @(posedge REF_CLK);
      SAFETY_OVERRIDE <= 1'b0;
      nw(1);
   endtask
   task final_report;
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge REF_CLK) begin
      if (PSEL && PENABLE && PREADY && !PWRITE && exq.size() > 0) begin
         got = exq.pop_front();
         chk({PSLVERR, PRDATA}, got);
      end
   end
   initial begin
      repeat (5000) @(posedge REF_CLK);
      num_errors++;
      final_report;
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      void'($urandom(32'h6de2));
      repeat (3) @(posedge REF_CLK);
      SYS_RST <= 1'b0;
      nw(1);
      chk(CONVERTER_OVERSAMPLING, 11'h008);
      chk({HIGHPASS_BYPASS, LOWPASS_BYPASS, IRQ}, 3'h6);
      apb(1'b1, 12'h0A0, 33'hFF);
      foreach (ra[j]) apb(1'b0, ra[j], {ra[j] == 12'h0A0, 32'h0});
      $display("reset test done");
      apb(1'b1, 12'h080, 33'h4);
      nw(10);
      chk(BIAS_READY, 1'b0);
      nw(15);
      chk(BIAS_READY, 1'b1);
      apb(1'b0, 12'h0C8, 33'h8);
      for (k = 0; k < 8; k++) begin
         apb(1'b1, 12'h080, 33'({k[2:0], 1'b1, k[1:0]}));
         nw(1);
         chk(CONVERTER_OVERSAMPLING, 11'h008 << k);
         chk({PLL_ON, DRIVE_ON, BANDGAP_ON, INPHASE_RX_ON, QUADRATURE_RX_ON},
            {{2{|k[1:0]}}, 1'b1, k[0], k[1]});
      end
      chk(BIAS_READY, 1'b1);
      $display("enable test done");
      for (k = 0; k < 32; k++) begin
         apb(1'b1, 12'h084, 33'(k << 3));
         nw(1);
         chk({HIGHPASS_BYPASS, HIGHPASS_WIDE}, {k[4:3] == 2'h0, k[4]});
         chk(LOWPASS_BYPASS, k[2:0] == 3'h0);
         if (k[2:0] != 3'h0) chk(LOWPASS_STEP, k[2] ? 2'h3 : 2'(k[1:0] - 1));
      end
      apb(1'b0, 12'h084, 33'hF8);
      $display("filter test done");
      apb(1'b1, 12'h098, 33'h10);
      apb(1'b1, 12'h09C, 33'h40);
      apb(1'b1, 12'h080, 33'h7);
      apb(1'b1, 12'h084, 33'h1);
      smp(20'hB_0000, 20'h0_0000);
      nw(1);
      chk({ABOVE_THRESHOLD, BELOW_THRESHOLD}, 2'h2);
      apb(1'b1, 12'h084, 33'h3);
      smp(20'h7_F000, 20'h0_5000);
      nw(1);
      chk({ABOVE_THRESHOLD, BELOW_THRESHOLD}, 2'h1);
      chk(IRQ, 1'b0);
      apb(1'b1, 12'h0C4, 33'h1);
      nw(1);
      chk(IRQ, 1'b1);
      apb(1'b1, 12'h0C0, 33'h1);
      nw(1);
      chk(IRQ, 1'b0);
      apb(1'b0, 12'h0C0, 33'h2);
      // only the in-phase channel on: the quadrature word 7_F000 must count as zero
      apb(1'b1, 12'h080, 33'h5);
      apb(1'b1, 12'h084, 33'h5);
      smp(20'h3_0000, 20'h7_F000);
      nw(25);
      chk({ABOVE_THRESHOLD, BELOW_THRESHOLD}, 2'h0);
      apb(1'b1, 12'h084, 33'h0);
      smp(20'h7_F000, 20'h0_0000);
      nw(1);
      chk({ABOVE_THRESHOLD, BELOW_THRESHOLD}, 2'h0);
      apb(1'b1, 12'h084, 33'h7);
      smp(20'h7_F000, 20'h0_0000);
      nw(1);
      chk({ABOVE_THRESHOLD, BELOW_THRESHOLD}, 2'h0);
      $display("threshold test done");
      apb(1'b1, 12'h088, 33'h3C);
      nw(1);
      chk({DRIVE_VOLTAGE_MAGNITUDE, DRIVE_CURRENT_RANGE}, 4'hF);
      v = 2'($urandom) & 2'h2;
      r = 2'($urandom) & 2'h1;
      ovr;
      chk({DRIVE_VOLTAGE_MAGNITUDE, DRIVE_CURRENT_RANGE}, {v, r});
      apb(1'b1, 12'h088, 33'h83);
      v = 2'h3;
      r = 2'h3;
      ovr;
      chk({EXTERNAL_RESISTOR, DRIVE_VOLTAGE_MAGNITUDE, DRIVE_CURRENT_RANGE, STIMULUS_TYPE},
         7'h43);
      apb(1'b0, 12'h088, 33'h83);
      $display("drive test done");
      @(posedge REF_CLK);
      LEADOFF_RAW <= 1'b1;
      nw(5);
      @(posedge REF_CLK);
      LEADOFF_RAW <= 1'b0;
      nw(1);
      chk(LEADOFF_STATUS, 1'b0);
      @(posedge REF_CLK);
      LEADOFF_RAW <= 1'b1;
      nw(8);
      chk(LEADOFF_STATUS, 1'b0);
      nw(5);
      chk(LEADOFF_STATUS, 1'b1);
      @(posedge REF_CLK);
      LEADOFF_RAW <= 1'b0;
      nw(2);
      chk(LEADOFF_STATUS, 1'b0);
      apb(1'b1, 12'h088, 33'hC3);
      @(posedge REF_CLK);
      LEADOFF_RAW <= 1'b1;
      nw(2);
      chk(LEADOFF_STATUS, 1'b1);
      @(posedge REF_CLK);
      LEADOFF_RAW <= 1'b0;
      apb(1'b0, 12'h0C0, 33'h6);
      $display("lead-off test done");
      final_report;
   end
endmodule // tb_top
`default_nettype wire
